// [mba_pkg.sv]
`default_nettype none
package mba_pkg;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int unsigned NPROC = 8;
  localparam int unsigned NDMA = 4;
  localparam int unsigned IDW = 3;

  // ----------------------------------------------------------------
  // timing and fixed values
  // ----------------------------------------------------------------
  // cycles after reset release before straps and identity are taken;
  // covers the three-stage input filter
  localparam logic [3:0] STRAP_WAIT = 4'h4;
  localparam logic [3:0] CNT_ONE = 4'h1;
  localparam logic [3:0] HIST_ZERO = 4'h0;
  localparam logic [NPROC-1:0] ONE_HOT0 = 8'h01;
  localparam logic [NPROC-1:0] NO_LINES = 8'h00;
  localparam logic [NDMA-1:0] NO_CHAN = 4'h0;

  // ----------------------------------------------------------------
  // pin inputs, all active low except identity and straps
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [NPROC-1:0] br_n;
    logic backoff_n;
    logic hreq_n;
    logic hgrant_n;
    logic cpa_n;
    logic dpa_n;
    logic [NDMA-1:0] dmar_n;
    logic [IDW-1:0] id;
    logic strap_bm;
    logic strap_lock;
  } mba_pins_s;

  localparam int unsigned PINS_W = $bits(mba_pins_s);
  localparam mba_pins_s PINS_RST = '{br_n: 8'hff, backoff_n: 1'b1,
    hreq_n: 1'b1, hgrant_n: 1'b1, cpa_n: 1'b1, dpa_n: 1'b1,
    dmar_n: 4'hf, id: 3'h0, strap_bm: 1'b0, strap_lock: 1'b0};

  // ----------------------------------------------------------------
  // registered pin and status outputs
  // ----------------------------------------------------------------
  typedef struct packed {
    logic br_low;
    logic drive_en;
    logic bm_n;
    logic lock_n;
    logic grant_n;
    logic grant_oe;
    logic cpa_oe;
    logic dpa_oe;
    logic io_wr_n;
    logic io_rd_n;
    logic io_en_n;
    logic io_oe;
    logic float_bus;
    logic sr_req;
    logic abort;
  } mba_out_s;

  localparam mba_out_s OUT_RST = '{br_low: 1'b0, drive_en: 1'b0,
    bm_n: 1'b1, lock_n: 1'b1, grant_n: 1'b1, grant_oe: 1'b0,
    cpa_oe: 1'b0, dpa_oe: 1'b0, io_wr_n: 1'b1, io_rd_n: 1'b1,
    io_en_n: 1'b1, io_oe: 1'b0, float_bus: 1'b1, sr_req: 1'b0,
    abort: 1'b0};

  typedef enum logic [2:0] {
    ST_START, ST_SLAVE, ST_MASTER, ST_SELFREF, ST_HOST, ST_BACKOFF
  } mba_state_e;

  typedef struct packed {
    mba_state_e st;
    logic [3:0] cnt;
    mba_pins_s s1;
    mba_pins_s s2;
    mba_pins_s s3;
    mba_pins_s flt;
    logic [IDW-1:0] id;
    logic strap_bm;
    logic strap_lock;
    logic [NPROC-1:0] other_prev;
    logic [3:0] cpa_hist;
    logic [3:0] dpa_hist;
    logic [NDMA-1:0] dmar_prev;
    logic [NDMA-1:0] pend;
    mba_out_s out;
  } mba_state_s;

endpackage
`default_nettype wire

// [mba_arbiter.sv]
`timescale 1ns/1ns
`default_nettype none
module mba_arbiter
  import mba_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // pins in
  input wire mba_pkg::mba_pins_s pins_i,
  // pins out
  output logic [mba_pkg::NPROC-1:0] bus_request_lines_o,
  output logic [mba_pkg::NPROC-1:0] bus_request_lines_oe_o,
  output logic master_indicator_n_o,
  output logic master_indicator_oe_o,
  output logic bus_lock_indicator_n_o,
  output logic bus_lock_indicator_oe_o,
  output logic host_grant_n_o,
  output logic host_grant_oe_o,
  output logic core_priority_access_o,
  output logic core_priority_access_oe_o,
  output logic dma_priority_access_o,
  output logic dma_priority_access_oe_o,
  output logic io_write_strobe_n_o,
  output logic io_read_strobe_n_o,
  output logic io_output_enable_n_o,
  output logic io_oe_o,
  // core and dma side
  input wire logic core_req_i,
  input wire logic lock_req_i,
  input wire logic dma_act_i,
  input wire logic [1:0] dma_ch_i,
  input wire logic [mba_pkg::NDMA-1:0] ch_init_i,
  input wire logic [mba_pkg::NDMA-1:0] ch_hiprio_i,
  input wire logic [mba_pkg::NDMA-1:0] ch_flyby_i,
  input wire logic [mba_pkg::NDMA-1:0] ch_flyby_rd_i,
  input wire logic [mba_pkg::NDMA-1:0] dma_ack_i,
  input wire logic data_cycle_i,
  input wire logic xfer_busy_i,
  input wire logic sdram_sr_ack_i,
  // status
  output logic [mba_pkg::NDMA-1:0] dma_pending_o,
  output logic bus_float_o,
  output logic sdram_selfref_req_o,
  output logic abort_o,
  output logic is_master_o,
  output logic host_owns_o,
  output logic [mba_pkg::IDW-1:0] id_o,
  output logic strap_bm_o,
  output logic strap_lock_o
);
  import mba_pkg::*;

  // ----------------------------------------------------------------
  // size checks
  // ----------------------------------------------------------------
  // the decode below assumes one request line per identity value
  if (NPROC != (1 << IDW) || NDMA != 4) begin : g_size_check
    $error("mba_arbiter: unsupported processor or channel count");
  end

  mba_state_s r_reg;
  mba_state_s r_next;
  logic [PINS_W-1:0] agree;
  logic [NPROC-1:0] own_mask;
  logic [NPROC-1:0] lower_mask;
  logic [NPROC-1:0] other_req;
  logic [NDMA-1:0] dmar_fall;
  logic want;
  logic hown;
  logic host_backoff;
  logic hreq;
  logic cpa_other;
  logic dpa_other;
  logic dma_hi;
  logic fly;
  logic take;
  logic preempt;
  logic owner;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    r_next = r_reg;
    // three-stage filter: a bit moves once stages two and three agree
    r_next.s1 = pins_i;
    r_next.s2 = r_reg.s1;
    r_next.s3 = r_reg.s2;
    agree = ~(r_reg.s2 ^ r_reg.s3);
    r_next.flt = mba_pins_s'((r_reg.s3 & agree) |
                             (r_reg.flt & ~agree));

    own_mask = ONE_HOT0 << r_reg.id;
    lower_mask = own_mask - ONE_HOT0;
    // unused lines read high, so they never look like requests
    other_req = ~r_reg.flt.br_n & ~own_mask;
    want = core_req_i | dma_act_i;
    // our own grant drive reads back late; grant_oe masks it only while set, so hown sees it for up to four cycles after release
    hown = ~r_reg.flt.hgrant_n & ~r_reg.out.grant_oe;
    host_backoff = ~r_reg.flt.backoff_n;
    hreq = ~r_reg.flt.hreq_n;
    dma_hi = dma_act_i & ch_hiprio_i[dma_ch_i];
    fly = dma_act_i & ch_flyby_i[dma_ch_i];
    // own drive is seen late through the filter, so the history masks it
    cpa_other = ~r_reg.flt.cpa_n & ~|r_reg.cpa_hist;
    dpa_other = ~r_reg.flt.dpa_n & ~|r_reg.dpa_hist;
    // from an idle bus the lowest identity wins, otherwise hold off
    take = want & ~hown & ~host_backoff &
           ((other_req == NO_LINES) |
            ((r_reg.other_prev == NO_LINES) &
             ((other_req & lower_mask) == NO_LINES)));
    preempt = (cpa_other & ~core_req_i & dma_act_i) |
              (dpa_other & dma_act_i & ~dma_hi & ~core_req_i);
    r_next.other_prev = other_req;
    r_next.out.abort = 1'b0;

    case (r_reg.st)
      ST_START: begin
        r_next.cnt = r_reg.cnt + CNT_ONE;
        if (r_reg.cnt == STRAP_WAIT) begin
          // identity and straps are taken once, after reset
          r_next.id = r_reg.flt.id;
          r_next.strap_bm = r_reg.flt.strap_bm;
          r_next.strap_lock = r_reg.flt.strap_lock;
          r_next.st = ST_SLAVE;
        end
      end
      ST_SLAVE: begin
        if (take) begin
          r_next.st = ST_MASTER;
        end
      end
      ST_MASTER: begin
        if (host_backoff) begin
          // drop the bus at once; the transaction is retried later
          r_next.out.abort = xfer_busy_i;
          r_next.st = ST_BACKOFF;
        end else if (hreq) begin
          if (!xfer_busy_i) begin
            r_next.st = ST_SELFREF;
          end
        end else if (preempt || !want) begin
          if (!xfer_busy_i) begin
            r_next.st = ST_SLAVE;
          end
        end
      end
      ST_SELFREF: begin
        if (sdram_sr_ack_i) begin
          r_next.st = ST_HOST;
        end
      end
      ST_HOST: begin
        if (!hreq) begin
          r_next.st = ST_SLAVE;
        end
      end
      ST_BACKOFF: begin
        if (!host_backoff) begin
          r_next.st = ST_SLAVE;
        end
      end
      default: begin
        r_next.st = ST_SLAVE;
      end
    endcase

    owner = (r_next.st == ST_MASTER) || (r_next.st == ST_SELFREF);
    r_next.out.drive_en = (r_next.st != ST_START);
    r_next.out.br_low = owner || (r_next.st == ST_HOST) ||
                        ((r_next.st == ST_SLAVE) && want && !hown &&
                         !host_backoff);
    r_next.out.bm_n = ~owner;
    r_next.out.lock_n = ~(owner & lock_req_i);
    r_next.out.grant_oe = owner || (r_next.st == ST_HOST);
    r_next.out.grant_n = ~(r_next.st == ST_HOST);
    r_next.out.sr_req = (r_next.st == ST_SELFREF) ||
                        (r_next.st == ST_HOST);
    r_next.out.float_bus = !(r_next.st == ST_MASTER);
    r_next.out.cpa_oe = core_req_i && (owner ||
                        (r_next.st == ST_SLAVE));
    r_next.out.dpa_oe = dma_hi && !core_req_i && (owner ||
                        (r_next.st == ST_SLAVE));
    r_next.cpa_hist = {r_reg.cpa_hist[2:0], r_reg.out.cpa_oe};
    r_next.dpa_hist = {r_reg.dpa_hist[2:0], r_reg.out.dpa_oe};

    // fly-by strobes only while we own the bus
    r_next.out.io_oe = (r_next.st == ST_MASTER);
    r_next.out.io_en_n = ~((r_next.st == ST_MASTER) && fly);
    r_next.out.io_wr_n = ~((r_next.st == ST_MASTER) && fly &&
                           data_cycle_i && ch_flyby_rd_i[dma_ch_i]);
    r_next.out.io_rd_n = ~((r_next.st == ST_MASTER) && fly &&
                           data_cycle_i && !ch_flyby_rd_i[dma_ch_i]);

    // a request landing on the cycle of its ack stays pending
    dmar_fall = r_reg.dmar_prev & ~r_reg.flt.dmar_n;
    r_next.dmar_prev = r_reg.flt.dmar_n;
    r_next.pend = (r_reg.pend & ~dma_ack_i) |
                  (dmar_fall & ch_init_i);
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      r_reg <= '{st: ST_START, cnt: HIST_ZERO, s1: PINS_RST,
                 s2: PINS_RST, s3: PINS_RST, flt: PINS_RST,
                 id: PINS_RST.id, strap_bm: PINS_RST.strap_bm,
                 strap_lock: PINS_RST.strap_lock,
                 other_prev: NO_LINES, cpa_hist: HIST_ZERO,
                 dpa_hist: HIST_ZERO, dmar_prev: PINS_RST.dmar_n,
                 pend: NO_CHAN, out: OUT_RST};
    end else begin
      r_reg <= r_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign bus_request_lines_oe_o = r_reg.out.drive_en ?
                                  (ONE_HOT0 << r_reg.id) : NO_LINES;
  assign bus_request_lines_o = ~({NPROC{r_reg.out.br_low}} &
                                 (ONE_HOT0 << r_reg.id));
  // strap pins stay undriven until the straps have been taken
  assign master_indicator_n_o = r_reg.out.bm_n;
  assign master_indicator_oe_o = r_reg.out.drive_en;
  assign bus_lock_indicator_n_o = r_reg.out.lock_n;
  assign bus_lock_indicator_oe_o = r_reg.out.drive_en;
  assign host_grant_n_o = r_reg.out.grant_n;
  assign host_grant_oe_o = r_reg.out.grant_oe;
  assign core_priority_access_o = 1'b0;
  assign core_priority_access_oe_o = r_reg.out.cpa_oe;
  assign dma_priority_access_o = 1'b0;
  assign dma_priority_access_oe_o = r_reg.out.dpa_oe;
  assign io_write_strobe_n_o = r_reg.out.io_wr_n;
  assign io_read_strobe_n_o = r_reg.out.io_rd_n;
  assign io_output_enable_n_o = r_reg.out.io_en_n;
  assign io_oe_o = r_reg.out.io_oe;
  assign dma_pending_o = r_reg.pend;
  assign bus_float_o = r_reg.out.float_bus;
  assign sdram_selfref_req_o = r_reg.out.sr_req;
  assign abort_o = r_reg.out.abort;
  assign is_master_o = ~r_reg.out.bm_n;
  assign host_owns_o = (r_reg.st == ST_HOST) ||
                       (~r_reg.flt.hgrant_n & ~r_reg.out.grant_oe);
  assign id_o = r_reg.id;
  assign strap_bm_o = r_reg.strap_bm;
  assign strap_lock_o = r_reg.strap_lock;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_br_own_only: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (bus_request_lines_oe_o & ~(ONE_HOT0 << id_o)) == NO_LINES)
    else $error("request line other than own is driven");

  a_br_id_select: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !bus_request_lines_o[id_o] |-> bus_request_lines_oe_o[id_o])
    else $error("own request line low but not driven");

  // judged from the filtered lines and the taken identity, not the masks
  a_arb_order: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (r_reg.st == ST_SLAVE && r_next.st == ST_MASTER) |->
    (~r_reg.flt.br_n & ((ONE_HOT0 << id_o) - ONE_HOT0)) == NO_LINES)
    else $error("took bus over a lower identity");

  a_backoff_drop: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (r_reg.st == ST_MASTER && host_backoff) |=>
    (bus_float_o && master_indicator_n_o))
    else $error("back-off did not release the bus");

  a_host_wait: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (r_reg.st == ST_MASTER && hreq && xfer_busy_i && !host_backoff) |=>
    host_grant_n_o)
    else $error("host granted before transaction ended");

  a_host_float: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !host_grant_n_o |-> (bus_float_o && !io_oe_o))
    else $error("bus driven while host granted");

  a_selfref_first: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $fell(host_grant_n_o) |-> $past(sdram_selfref_req_o, 1))
    else $error("grant without sdram self-refresh");

  a_grant_hold: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (!host_grant_n_o && hreq) |=> !host_grant_n_o)
    else $error("host grant dropped while request active");

  a_grant_owner: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    host_grant_oe_o |-> (!master_indicator_n_o || r_reg.st == ST_HOST))
    else $error("non-owner drives host grant");

  a_cpa_drive: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (r_reg.st == ST_MASTER && core_req_i && !host_backoff && !hreq) |=>
    core_priority_access_oe_o)
    else $error("core access without core priority");

  a_dma_ignore: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $rose(dma_pending_o[0]) |-> $past(ch_init_i[0], 1))
    else $error("request taken on uninitialised channel");

  a_flyby_only: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !io_output_enable_n_o |-> (io_oe_o && $past(fly, 1)))
    else $error("io enable outside fly-by");

  a_flyby_strobe: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (!io_write_strobe_n_o || !io_read_strobe_n_o) |->
    (!io_output_enable_n_o && io_write_strobe_n_o != io_read_strobe_n_o))
    else $error("fly-by strobe without enable or both strobes");

endmodule // mba_arbiter
`default_nettype wire

// [mba_peer_model.sv]
`timescale 1ns/1ns
`default_nettype none
module mba_peer_model
  import mba_pkg::*;
(
  // scenario controls
  input wire logic [mba_pkg::NPROC-1:0] peer_req_i,
  input wire logic host_want_i,
  input wire logic host_backoff_i,
  input wire logic peer_cpa_i,
  input wire logic peer_dpa_i,
  input wire logic peer_grant_i,
  input wire logic [mba_pkg::NDMA-1:0] dmar_n_i,
  input wire logic [mba_pkg::IDW-1:0] id_i,
  input wire logic [1:0] strap_i,
  // device pins
  input wire logic [mba_pkg::NPROC-1:0] br_i,
  input wire logic [mba_pkg::NPROC-1:0] br_oe_i,
  input wire logic grant_n_i,
  input wire logic grant_oe_i,
  input wire logic cpa_oe_i,
  input wire logic dpa_oe_i,
  // resolved wire levels
  output var mba_pkg::mba_pins_s pins_o
);
  // ----
  // wire resolution
  // ----
  // lines nobody pulls sit at their pull-up, so absent peers read high
  always_comb begin
    for (int i = 0; i < NPROC; i++) begin
      pins_o.br_n[i] = br_oe_i[i] ? br_i[i] : !peer_req_i[i];
    end
    pins_o.backoff_n = !host_backoff_i;
    pins_o.hreq_n = !host_want_i;
    // another owner may grant the host; otherwise the pull-up wins
    pins_o.hgrant_n = grant_oe_i ? grant_n_i : !peer_grant_i;
    pins_o.cpa_n = !(cpa_oe_i | peer_cpa_i);
    pins_o.dpa_n = !(dpa_oe_i | peer_dpa_i);
    pins_o.dmar_n = dmar_n_i;
    pins_o.id = id_i;
    pins_o.strap_bm = strap_i[1];
    pins_o.strap_lock = strap_i[0];
  end
endmodule // mba_peer_model
`default_nettype wire

// [test_multiprocessor_bus_arbitration.sv]
`timescale 1ns/1ns
`default_nettype none
module test_multiprocessor_bus_arbitration;
  import mba_pkg::*;
  typedef struct packed {
    logic [1:0] ch;
    logic init;
    logic pend;
  } mba_row_s;
  mba_row_s rows [8] = '{'{2'h0, 1'b1, 1'b1}, '{2'h1, 1'b1, 1'b1},
    '{2'h2, 1'b1, 1'b1}, '{2'h3, 1'b1, 1'b1}, '{2'h0, 1'b0, 1'b0},
    '{2'h1, 1'b0, 1'b0}, '{2'h2, 1'b0, 1'b0}, '{2'h3, 1'b0, 1'b0}};
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [NPROC-1:0] peer_req = 8'h00;
  logic host_want = 1'b0, host_backoff = 1'b0, peer_cpa = 1'b0, peer_dpa = 1'b0;
  logic peer_grant = 1'b0;
  logic [NDMA-1:0] dmar_n = 4'hf, expv;
  logic [IDW-1:0] id = 3'h5;
  logic [1:0] strap = 2'h2;
  logic core_req = 1'b0, lock_req = 1'b0, dma_act = 1'b0;
  logic data_cycle = 1'b0, xfer_busy = 1'b0, sr_ack = 1'b0;
  logic [1:0] dma_ch = 2'h2;
  logic [NDMA-1:0] ch_init = 4'h0, ch_hi = 4'h0, ch_fly = 4'h0;
  logic [NDMA-1:0] ch_rd = 4'h0, dma_ack = 4'h0, pend;
  mba_pins_s pins;
  logic [NPROC-1:0] br, br_oe;
  logic bm_n, bm_oe, lock_n, grant_n, grant_oe, cpa_oe, dpa_oe;
  logic io_wr_n, io_rd_n, io_en_n, io_oe, flt, sr_req, abort;
  logic [IDW-1:0] id_cap;
  logic lock_oe, cpa_lvl, dpa_lvl, is_m, h_owns;
  logic s_bm, s_lock;
  int mismatches = 0;
  int checks = 0;
  bit seen;

  always #50 clk_i = ~clk_i;

  mba_peer_model peers (.peer_req_i(peer_req), .host_want_i(host_want),
    .host_backoff_i(host_backoff), .peer_cpa_i(peer_cpa), .peer_dpa_i(peer_dpa),
    .dmar_n_i(dmar_n), .id_i(id), .strap_i(strap), .br_i(br),
    .br_oe_i(br_oe), .grant_n_i(grant_n), .grant_oe_i(grant_oe),
    .cpa_oe_i(cpa_oe), .dpa_oe_i(dpa_oe), .peer_grant_i(peer_grant),
    .pins_o(pins));

  mba_arbiter uut (.clk_i(clk_i), .rst_n_i(rst_n_i), .pins_i(pins),
    .bus_request_lines_o(br), .bus_request_lines_oe_o(br_oe),
    .master_indicator_n_o(bm_n), .master_indicator_oe_o(bm_oe),
    .bus_lock_indicator_n_o(lock_n), .bus_lock_indicator_oe_o(lock_oe),
    .host_grant_n_o(grant_n), .host_grant_oe_o(grant_oe),
    .core_priority_access_o(cpa_lvl), .core_priority_access_oe_o(cpa_oe),
    .dma_priority_access_o(dpa_lvl), .dma_priority_access_oe_o(dpa_oe),
    .io_write_strobe_n_o(io_wr_n), .io_read_strobe_n_o(io_rd_n),
    .io_output_enable_n_o(io_en_n), .io_oe_o(io_oe),
    .core_req_i(core_req), .lock_req_i(lock_req), .dma_act_i(dma_act),
    .dma_ch_i(dma_ch), .ch_init_i(ch_init), .ch_hiprio_i(ch_hi),
    .ch_flyby_i(ch_fly), .ch_flyby_rd_i(ch_rd), .dma_ack_i(dma_ack),
    .data_cycle_i(data_cycle), .xfer_busy_i(xfer_busy),
    .sdram_sr_ack_i(sr_ack), .dma_pending_o(pend), .bus_float_o(flt),
    .sdram_selfref_req_o(sr_req), .abort_o(abort), .is_master_o(is_m),
    .host_owns_o(h_owns), .id_o(id_cap), .strap_bm_o(s_bm),
    .strap_lock_o(s_lock));

  // ----
  // helpers
  // ----
  task automatic check(input string name, input logic [7:0] seen_v,
      input logic [7:0] exp_v);
    checks++;
    if (seen_v !== exp_v) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", name, exp_v, seen_v);
    end
  endtask

  task automatic finish_test;
    if (mismatches == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk_i);
  endtask

  // bounded wait on the master indicator; the caller compares afterwards
  task automatic wait_bm(input logic v);
    for (int k = 0; k < 20 && bm_n !== v; k++) cyc(1);
  endtask

  task automatic reset_to(input logic [IDW-1:0] new_id);
    rst_n_i = 1'b0;
    id = new_id;
    cyc(4);
    rst_n_i = 1'b1;
    cyc(8);
  endtask

  task automatic flyby(input logic f, input logic r, input logic d,
      input logic [2:0] e);
    ch_fly = {1'b0, f, 2'b00};
    ch_rd = {1'b0, r, 2'b00};
    data_cycle = d;
    cyc(2);
    check("io strobes", {io_wr_n, io_rd_n, io_en_n}, e);
  endtask

  initial begin
    cyc(3);
    check("oe in reset", br_oe, 8'h00);
    check("bm oe in reset", {bm_oe, lock_oe}, 2'h0);
    check("float in reset", flt, 1'b1);
    reset_to(3'h5);
    check("own line oe", br_oe, 8'h20);
    check("id taken", id_cap, 3'h5);
    check("straps", {s_bm, s_lock}, strap);
    check("strap oe", {bm_oe, lock_oe}, 2'h3);
    // ordinary cases: dma requests, synchroniser latency, init gating
    foreach (rows[r]) begin
      ch_init = rows[r].init ? 4'hf : ~(4'h1 << rows[r].ch);
      expv = rows[r].pend ? 4'h1 << rows[r].ch : 4'h0;
      dmar_n[rows[r].ch] = 1'b0;
      cyc(4);
      check("pending early", pend, 4'h0);
      cyc(1);
      check("pending", pend, expv);
      dmar_n = 4'hf;
      dma_ack = 4'hf;
      cyc(1);
      dma_ack = 4'h0;
      cyc(1);
    end
    // another owner has granted the host: we must not take the bus
    peer_grant = 1'b1;
    cyc(5);
    check("host seen", h_owns, 1'b1);
    core_req = 1'b1;
    cyc(3);
    check("refused bm", bm_n, 1'b1);
    check("refused line", br, 8'hff);
    core_req = 1'b0;
    peer_grant = 1'b0;
    cyc(5);
    check("host gone", h_owns, 1'b0);
    // a lower peer already holds its line: we wait with our line low
    peer_req = 8'h04;
    cyc(4);
    core_req = 1'b1;
    cyc(4);
    check("wait bm", bm_n, 1'b1);
    check("wait line", br, 8'hdf);
    peer_req = 8'h00;
    wait_bm(1'b0);
    check("take bm", {bm_n, is_m}, 2'h1);
    check("core prio", {cpa_lvl, cpa_oe}, 2'h1);
    lock_req = 1'b1;
    cyc(2);
    check("lock", lock_n, 1'b0);
    lock_req = 1'b0;
    dma_act = 1'b1;
    flyby(1'b1, 1'b1, 1'b1, 3'h2);
    flyby(1'b1, 1'b0, 1'b1, 3'h4);
    flyby(1'b1, 1'b0, 1'b0, 3'h6);
    flyby(1'b0, 1'b0, 1'b1, 3'h7);
    // dma alone now: the core no longer shares the access
    ch_hi = 4'h4;
    core_req = 1'b0;
    cyc(2);
    check("dma prio", {dpa_lvl, dpa_oe}, 2'h1);
    ch_hi = 4'h0;
    // a preempting peer also raises its own request line
    peer_cpa = 1'b1;
    peer_req = 8'h04;
    wait_bm(1'b1);
    check("core preempt", bm_n, 1'b1);
    cyc(4);
    check("stay off", bm_n, 1'b1);
    peer_cpa = 1'b0;
    peer_req = 8'h00;
    cyc(6);
    wait_bm(1'b0);
    peer_dpa = 1'b1;
    peer_req = 8'h04;
    wait_bm(1'b1);
    check("dma preempt", bm_n, 1'b1);
    peer_dpa = 1'b0;
    peer_req = 8'h00;
    dma_act = 1'b0;
    core_req = 1'b1;
    xfer_busy = 1'b1;
    cyc(6);
    wait_bm(1'b0);
    host_want = 1'b1;
    cyc(8);
    check("hold for xfer", sr_req, 1'b0);
    xfer_busy = 1'b0;
    for (int k = 0; k < 10 && sr_req !== 1'b1; k++) cyc(1);
    check("selfref req", sr_req, 1'b1);
    check("no early grant", grant_n, 1'b1);
    sr_ack = 1'b1;
    cyc(2);
    check("grant", {grant_n, grant_oe, h_owns}, 3'h3);
    check("floated", {flt, io_oe}, 2'h2);
    cyc(10);
    check("grant held", grant_n, 1'b0);
    host_want = 1'b0;
    cyc(2);
    check("grant lag", grant_n, 1'b0);
    cyc(3);
    check("grant off", grant_n, 1'b1);
    sr_ack = 1'b0;
    wait_bm(1'b0);
    xfer_busy = 1'b1;
    host_backoff = 1'b1;
    seen = 1'b0;
    for (int k = 0; k < 8 && flt !== 1'b1; k++) begin
      cyc(1);
      seen |= (abort === 1'b1);
    end
    check("abort seen", seen, 1'b1);
    check("backoff bm", {flt, bm_n}, 2'h3);
    host_backoff = 1'b0;
    xfer_busy = 1'b0;
    // reset in mid-run, while owning the bus, with a new identity
    wait_bm(1'b0);
    for (int n = 0; n < 8; n += 7) begin
      reset_to(n[2:0]);
      check("line oe", br_oe, 8'h1 << n);
    end
    finish_test();
  end

  // whole sequence takes well under a thousand cycles
  initial begin
    #(3000 * 100);
    mismatches++;
    finish_test();
  end
endmodule // test_multiprocessor_bus_arbitration
`default_nettype wire
